// ===== hw/ftcm_pkg.sv
// Purpose: shared constants for the fault threshold and checksum monitor
// Assumes: 20 MHz system clock, word-aligned register port
// Notes:   offsets are byte addresses; user bytes sit one per word
package ftcm_pkg;

  // register offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STORED_CHECKSUM_STO  = 12'h004;
  localparam logic [11:0] OFF_STORED_CHECKSUM_CMP  = 12'h008;
  localparam logic [11:0] OFF_CMP_DAC   = 12'h00C;
  localparam logic [11:0] OFF_MASKS     = 12'h010;
  localparam logic [11:0] OFF_AUX_FLAGS = 12'h014;
  localparam logic [11:0] OFF_CMP_FLAGS = 12'h018;
  localparam logic [11:0] OFF_CMP_FORCE = 12'h01C;
  localparam logic [11:0] OFF_SYS_FLAGS = 12'h020;
  localparam logic [11:0] OFF_TMO_CNT   = 12'h024;
  localparam logic [11:0] OFF_AUX_LIM   = 12'h040;
  localparam logic [11:0] OFF_AUX_RES   = 12'h060;
  localparam logic [11:0] OFF_USER      = 12'h400;

  // control register fields
  localparam int CTRL_UNLATCHED = 0;
  localparam int CTRL_CFG_LSB   = 1;
  localparam int CTRL_CHAN_LSB  = 4;
  localparam int CTRL_CRST_DIS  = 9;
  localparam int CTRL_FOEN_LSB  = 16;

  // fault output group enables
  localparam int FO_AUX_UNDER = 0;
  localparam int FO_AUX_OVER  = 1;
  localparam int FO_CMP_UNDER = 2;
  localparam int FO_CMP_OVER  = 3;
  localparam int FO_COMM      = 4;
  localparam int FO_SYS       = 5;

  // system flag / mask positions, and the lsb of the under DAC field
  localparam int SYS_TIMEOUT  = 0;
  localparam int SYS_STORED_CHECKSUM_ERR = 1;
  localparam int DAC_UNDER_LSB = 8;

  // comparator configuration encodings
  localparam logic [1:0] CMP_CFG_BOTH = 2'h0;
  localparam logic [1:0] CMP_CFG_OVER = 2'h1;
  localparam logic [1:0] CMP_CFG_NONE = 2'h2;

  // reset values
  localparam logic [1:0]  RST_CMP_CFG   = CMP_CFG_BOTH;
  localparam logic [4:0]  RST_CHAN_CNT  = 5'h10;
  localparam logic [15:0] RST_UNDER_LIM = 16'h0000;
  localparam logic [15:0] RST_OVER_LIM  = 16'hFFFF;
  localparam logic [6:0]  RST_DAC       = 7'h00;
  localparam logic [31:0] RST_STORED_CHECKSUM      = 32'h0000_0000;

  // counter access: upper 24 bits reachable, low 8 forced to ones
  localparam int          TMO_LOW_BITS  = 8;
  localparam logic [7:0]  TMO_LOW_FILL  = 8'hFF;

  // timing
  localparam int CLK_FREQ_HZ  = 20_000_000;
  localparam int TICK_FREQ_HZ = 4_000;
  localparam int TICK_CYCLES  = CLK_FREQ_HZ / TICK_FREQ_HZ;

  // user bytes that feed the checksum; the index is the byte address
  localparam int USER_BYTES = 228;
  localparam int USER_WORDS = USER_BYTES / 4;

  function automatic logic stored_checksum_used(input int unsigned a);
    case (a) inside
      3, [4:7], 10, 11, [13:15], [16:19], 20, 21, 30, 31,
      34, 35, 36, 37, 40, 50, 51, [52:55], [61:63], [64:67],
      68, [104:107], 108, 110, 111, [120:123], 125, [140:177],
      [200:207], 210, 211, [212:227]: stored_checksum_used = 1'b1;
      default:                       stored_checksum_used = 1'b0;
    endcase
  endfunction

endpackage

// ===== hw/ftcm_stored_checksum.sv
// Purpose: user-space byte store and running user checksum
// Assumes: one byte written per cycle at most
// Notes:   the sum is recomputed every cycle from the stored bytes
`timescale 1ns/1ps
module ftcm_stored_checksum (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // byte write and read
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  // checksum
  output logic      [31:0] sum_o
);

  typedef struct packed {
    logic [ftcm_pkg::USER_BYTES-1:0][7:0] mem;
    logic [31:0]                          sum;
  } ftcm_stored_checksum_state_t;

  ftcm_stored_checksum_state_t s_q, s_d;
  logic [31:0]      word;

  always_comb begin
    s_d  = s_q;
    word = 32'h0000_0000;
    s_d.sum = 32'h0000_0000;
    // each term packs four bytes, lowest address in the top byte
    for (int w = 0; w < ftcm_pkg::USER_WORDS; w++) begin
      for (int b = 0; b < 4; b++) begin
        word[31-8*b -: 8] = ftcm_pkg::stored_checksum_used(4*w+b) ?
                            s_q.mem[4*w+b] : 8'h00;
      end
      s_d.sum = s_d.sum + word;
    end
    if (wr_i && (addr_i < 8'(ftcm_pkg::USER_BYTES))) begin
      s_d.mem[addr_i] = wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = (addr_i < 8'(ftcm_pkg::USER_BYTES)) ? s_q.mem[addr_i]
                                                       : 8'h00;
  assign sum_o   = s_q.sum;

endmodule

// ===== hw/ftcm_top.sv
// Purpose: aux limits, window comparator faults, comm faults, timeout
//          counter and user checksum check behind a plain register port
// Assumes: all inputs synchronous to mclk_i; comparator inputs are the
//          already-sampled analog comparator outputs
// Notes:   fault_n_o low on any enabled fault; tone toggles only while clean
`timescale 1ns/1ps

module ftcm_top #(
  parameter int AUX_CH      = 8,
  parameter int CELL_CH     = 16,
  parameter int COMM_ERRS   = 8,
  parameter int TICK_CYCLES = ftcm_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // register port
  input  wire logic [11:0]          addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [31:0]          rdata_o,
  // aux conversion results
  input  wire logic                 aux_valid_i,
  input  wire logic [2:0]           aux_chan_i,
  input  wire logic [15:0]          aux_data_i,
  // secondary window comparators
  input  wire logic [CELL_CH-1:0]   cmp_under_i,
  input  wire logic [CELL_CH-1:0]   cmp_over_i,
  output logic      [6:0]           comparator_over_dac_o,
  output logic      [6:0]           comparator_under_dac_o,
  output logic      [CELL_CH-1:0]   cmp_chan_en_o,
  // communication
  input  wire logic [COMM_ERRS-1:0] comm_err_i,
  input  wire logic                 frame_ok_i,
  // fault pins
  output logic                      fault_n_o,
  output logic                      fault_tone_out_o
);

  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic                             unlatched;
    logic [1:0]                       cmp_cfg;
    logic [4:0]                       channel_count;
    logic                             counter_reset_disable;
    logic [5:0]                       fo_en;
    logic [31:0]                      stored_checksum;
    logic [6:0]                       over_dac;
    logic [6:0]                       under_dac;
    logic [7:0]                       comm_fault_mask;
    logic [7:0]                       system_fault_mask;
    logic [AUX_CH-1:0][15:0]          aux_res;
    logic [AUX_CH-1:0][15:0]          aux_under_limit;
    logic [AUX_CH-1:0][15:0]          aux_over_limit;
    logic [AUX_CH-1:0]                aux_under_flag;
    logic [AUX_CH-1:0]                aux_over_flag;
    logic [CELL_CH-1:0]               cmp_uf;
    logic [CELL_CH-1:0]               cmp_of;
    logic [CELL_CH-1:0]               cmp_forced;
    logic                             cmp_en_prev;
    logic [COMM_ERRS-1:0]             comm_f;
    logic                             tmo_f;
    logic                             stored_checksum_err;
    logic [DIV_W-1:0]                 div;
    logic [31:0]                      cnt;
    logic [31:0]                      rdata;
    logic                             fault_n;
    logic                             tone;
    logic [CELL_CH-1:0]               chan_en;
  } ftcm_state_t;

  ftcm_state_t s_q, s_d;

  logic [AUX_CH-1:0]  aux_u_cond;
  logic [AUX_CH-1:0]  aux_o_cond;
  logic [CELL_CH-1:0] cmp_u_cond;
  logic [CELL_CH-1:0] cmp_o_cond;
  logic [CELL_CH-1:0] en_mask;
  logic               cmp_en;
  logic               cmp_rise;
  logic               tick;
  logic               wr_user;
  logic [7:0]         user_rdata;
  logic [31:0]        stored_checksum_now;
  logic               any_fault;

  // channels below the programmed count are live
  function automatic logic [CELL_CH-1:0] chan_mask(input logic [4:0] n);
    logic [CELL_CH-1:0] m;
    m = '0;
    for (int i = 0; i < CELL_CH; i++) begin
      m[i] = (5'(i) < n);
    end
    return m;
  endfunction

  function automatic logic wr_at(input logic [11:0] off);
    return wr_i && (addr_i == off);
  endfunction

  assign wr_user = wr_i && (addr_i >= ftcm_pkg::OFF_USER)
                   && (addr_i[1:0] == 2'h0);

  ftcm_stored_checksum u_stored_checksum (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (wr_user),
    .addr_i  (addr_i[9:2]),
    .wdata_i (wdata_i[7:0]),
    .rdata_o (user_rdata),
    .sum_o   (stored_checksum_now)
  );

  // conditions re-evaluated every cycle from stored results
  always_comb begin
    for (int i = 0; i < AUX_CH; i++) begin
      aux_u_cond[i] = s_q.aux_res[i] < s_q.aux_under_limit[i];
      aux_o_cond[i] = s_q.aux_res[i] > s_q.aux_over_limit[i];
    end
  end

  assign en_mask    = chan_mask(s_q.channel_count);
  assign cmp_en     = (s_q.cmp_cfg == ftcm_pkg::CMP_CFG_BOTH) ||
                      (s_q.cmp_cfg == ftcm_pkg::CMP_CFG_OVER);
  assign cmp_o_cond = cmp_en ? (cmp_over_i & en_mask) : '0;
  assign cmp_u_cond = (s_q.cmp_cfg == ftcm_pkg::CMP_CFG_BOTH) ?
                      (cmp_under_i & en_mask) : '0;
  assign cmp_rise   = cmp_en && !s_q.cmp_en_prev;
  assign tick       = (s_q.div == DIV_LAST);

  always_comb begin
    s_d = s_q;
    s_d.cmp_en_prev = cmp_en;
    s_d.chan_en     = en_mask;
    s_d.div = tick ? '0 : s_q.div + DIV_W'(1);

    // configuration writes
    if (wr_at(ftcm_pkg::OFF_CTRL)) begin
      s_d.unlatched     = wdata_i[ftcm_pkg::CTRL_UNLATCHED];
      s_d.cmp_cfg       = wdata_i[ftcm_pkg::CTRL_CFG_LSB +: 2];
      s_d.channel_count = wdata_i[ftcm_pkg::CTRL_CHAN_LSB +: 5];
      s_d.counter_reset_disable = wdata_i[ftcm_pkg::CTRL_CRST_DIS];
      s_d.fo_en         = wdata_i[ftcm_pkg::CTRL_FOEN_LSB +: 6];
    end
    if (wr_at(ftcm_pkg::OFF_STORED_CHECKSUM_STO)) begin
      s_d.stored_checksum = wdata_i;
    end
    if (wr_at(ftcm_pkg::OFF_CMP_DAC)) begin
      s_d.over_dac  = wdata_i[6:0];
      s_d.under_dac = wdata_i[ftcm_pkg::DAC_UNDER_LSB +: 7];
    end
    if (wr_at(ftcm_pkg::OFF_MASKS)) begin
      s_d.comm_fault_mask   = wdata_i[7:0];
      s_d.system_fault_mask = wdata_i[15:8];
    end
    for (int i = 0; i < AUX_CH; i++) begin
      if (wr_at(ftcm_pkg::OFF_AUX_LIM + 12'(4*i))) begin
        s_d.aux_under_limit[i] = wdata_i[15:0];
        s_d.aux_over_limit[i]  = wdata_i[31:16];
      end
    end
    if (aux_valid_i && (int'(aux_chan_i) < AUX_CH)) begin
      s_d.aux_res[aux_chan_i] = aux_data_i;
    end

    // fault flags: set wins over a write-one clear
    if (s_q.unlatched) begin
      s_d.aux_under_flag = aux_u_cond;
      s_d.aux_over_flag  = aux_o_cond;
      s_d.cmp_uf         = cmp_u_cond;
      s_d.cmp_of         = cmp_o_cond | s_q.cmp_forced;
    end else begin
      s_d.aux_under_flag = aux_u_cond | (s_q.aux_under_flag &
        ~(wr_at(ftcm_pkg::OFF_AUX_FLAGS) ? wdata_i[7:0] : 8'h00));
      s_d.aux_over_flag  = aux_o_cond | (s_q.aux_over_flag &
        ~(wr_at(ftcm_pkg::OFF_AUX_FLAGS) ? wdata_i[15:8] : 8'h00));
      s_d.cmp_uf = cmp_u_cond | (s_q.cmp_uf &
        ~(wr_at(ftcm_pkg::OFF_CMP_FLAGS) ? wdata_i[15:0] : 16'h0000));
      s_d.cmp_of = cmp_o_cond | s_q.cmp_forced | (s_q.cmp_of &
        ~(wr_at(ftcm_pkg::OFF_CMP_FLAGS) ? wdata_i[31:16] : 16'h0000));
    end
    // a re-enable raises sticky over faults until the host clears them
    s_d.cmp_forced = (cmp_rise ? en_mask : '0) | (s_q.cmp_forced &
      ~(wr_at(ftcm_pkg::OFF_CMP_FORCE) ? wdata_i[15:0] : 16'h0000));

    s_d.comm_f = (comm_err_i & ~s_q.comm_fault_mask) | (s_q.comm_f &
      ~(wr_at(ftcm_pkg::OFF_SYS_FLAGS) ? wdata_i[15:8] : 8'h00));
    s_d.stored_checksum_err = (s_q.stored_checksum != stored_checksum_now);

    // timeout counter; a counter write outranks a frame reset
    if (wr_at(ftcm_pkg::OFF_TMO_CNT)) begin
      s_d.cnt = {wdata_i[23:0], ftcm_pkg::TMO_LOW_FILL};
    end else if (frame_ok_i && !s_q.counter_reset_disable) begin
      s_d.cnt = 32'h0000_0000;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
    s_d.tmo_f = (tick && (s_q.cnt == 32'hFFFF_FFFF) &&
                 !wr_at(ftcm_pkg::OFF_TMO_CNT) &&
                 !(frame_ok_i && !s_q.counter_reset_disable) &&
                 !s_q.system_fault_mask[ftcm_pkg::SYS_TIMEOUT]) ||
                (s_q.tmo_f && !(wr_at(ftcm_pkg::OFF_SYS_FLAGS) &&
                 wdata_i[ftcm_pkg::SYS_TIMEOUT]));

    // fault pins
    any_fault =
      (|s_q.aux_under_flag && s_q.fo_en[ftcm_pkg::FO_AUX_UNDER]) ||
      (|s_q.aux_over_flag  && s_q.fo_en[ftcm_pkg::FO_AUX_OVER])  ||
      (|s_q.cmp_uf         && s_q.fo_en[ftcm_pkg::FO_CMP_UNDER]) ||
      (|s_q.cmp_of         && s_q.fo_en[ftcm_pkg::FO_CMP_OVER])  ||
      (|s_q.comm_f         && s_q.fo_en[ftcm_pkg::FO_COMM])      ||
      ((s_q.tmo_f || s_q.stored_checksum_err) && s_q.fo_en[ftcm_pkg::FO_SYS]);
    s_d.fault_n = !any_fault;
    s_d.tone    = any_fault ? 1'b0 : (s_q.tone ^ tick);

    // read data, valid in the cycle after the strobe only
    s_d.rdata = 32'h0000_0000;
    if (rd_i) begin
      if (addr_i == ftcm_pkg::OFF_CTRL) begin
        s_d.rdata[ftcm_pkg::CTRL_UNLATCHED]     = s_q.unlatched;
        s_d.rdata[ftcm_pkg::CTRL_CFG_LSB +: 2]  = s_q.cmp_cfg;
        s_d.rdata[ftcm_pkg::CTRL_CHAN_LSB +: 5] = s_q.channel_count;
        s_d.rdata[ftcm_pkg::CTRL_CRST_DIS] = s_q.counter_reset_disable;
        s_d.rdata[ftcm_pkg::CTRL_FOEN_LSB +: 6] = s_q.fo_en;
      end else if (addr_i == ftcm_pkg::OFF_STORED_CHECKSUM_STO) begin
        s_d.rdata = s_q.stored_checksum;
      end else if (addr_i == ftcm_pkg::OFF_STORED_CHECKSUM_CMP) begin
        s_d.rdata = stored_checksum_now;
      end else if (addr_i == ftcm_pkg::OFF_CMP_DAC) begin
        s_d.rdata[6:0] = s_q.over_dac;
        s_d.rdata[ftcm_pkg::DAC_UNDER_LSB +: 7] = s_q.under_dac;
      end else if (addr_i == ftcm_pkg::OFF_MASKS) begin
        s_d.rdata[15:0] = {s_q.system_fault_mask, s_q.comm_fault_mask};
      end else if (addr_i == ftcm_pkg::OFF_AUX_FLAGS) begin
        s_d.rdata[15:0] = {s_q.aux_over_flag, s_q.aux_under_flag};
      end else if (addr_i == ftcm_pkg::OFF_CMP_FLAGS) begin
        s_d.rdata = {s_q.cmp_of, s_q.cmp_uf};
      end else if (addr_i == ftcm_pkg::OFF_CMP_FORCE) begin
        s_d.rdata[15:0] = s_q.cmp_forced;
      end else if (addr_i == ftcm_pkg::OFF_SYS_FLAGS) begin
        s_d.rdata[ftcm_pkg::SYS_TIMEOUT]  = s_q.tmo_f;
        s_d.rdata[ftcm_pkg::SYS_STORED_CHECKSUM_ERR] = s_q.stored_checksum_err;
        s_d.rdata[15:8] = s_q.comm_f;
      end else if (addr_i == ftcm_pkg::OFF_TMO_CNT) begin
        s_d.rdata[23:0] = s_q.cnt[31:ftcm_pkg::TMO_LOW_BITS];
      end else if (addr_i >= ftcm_pkg::OFF_USER) begin
        s_d.rdata[7:0] = user_rdata;
      end else begin
        for (int i = 0; i < AUX_CH; i++) begin
          if (addr_i == ftcm_pkg::OFF_AUX_LIM + 12'(4*i)) begin
            s_d.rdata = {s_q.aux_over_limit[i], s_q.aux_under_limit[i]};
          end
          if (addr_i == ftcm_pkg::OFF_AUX_RES + 12'(4*i)) begin
            s_d.rdata[15:0] = s_q.aux_res[i];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q                 <= '0;
      s_q.cmp_cfg         <= ftcm_pkg::RST_CMP_CFG;
      s_q.cmp_en_prev     <= 1'b1;
      s_q.channel_count   <= ftcm_pkg::RST_CHAN_CNT;
      s_q.stored_checksum <= ftcm_pkg::RST_STORED_CHECKSUM;
      s_q.over_dac        <= ftcm_pkg::RST_DAC;
      s_q.under_dac       <= ftcm_pkg::RST_DAC;
      s_q.aux_under_limit <= {AUX_CH{ftcm_pkg::RST_UNDER_LIM}};
      s_q.aux_over_limit  <= {AUX_CH{ftcm_pkg::RST_OVER_LIM}};
      s_q.fault_n         <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o                = s_q.rdata;
  assign comparator_over_dac_o  = s_q.over_dac;
  assign comparator_under_dac_o = s_q.under_dac;
  assign cmp_chan_en_o          = s_q.chan_en;
  assign fault_n_o              = s_q.fault_n;
  assign fault_tone_out_o       = s_q.tone;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_reenable;
    cmp_en && !s_q.cmp_en_prev;
  endsequence

  a_stored_checksum_mismatch: assert property (
    (s_q.stored_checksum != stored_checksum_now) |=> s_q.stored_checksum_err)
    else $error("checksum mismatch not flagged");
  a_aux_latch_set: assert property (
    (aux_u_cond != '0) |=>
      ((s_q.aux_under_flag & $past(aux_u_cond)) == $past(aux_u_cond)))
    else $error("aux under breach not flagged");
  a_aux_follow: assert property (
    s_q.unlatched && !wr_at(ftcm_pkg::OFF_CTRL) |=>
      s_q.aux_over_flag == $past(aux_o_cond))
    else $error("unlatched aux flag did not follow");
  a_cmp_chan_gate: assert property (
    s_q.unlatched |=> (s_q.cmp_uf & ~$past(en_mask)) == '0)
    else $error("comparator flag on disabled channel");
  a_no_under_only: assert property (
    (s_q.cmp_cfg != ftcm_pkg::CMP_CFG_BOTH) |-> cmp_u_cond == '0)
    else $error("under fault without both mode");
  a_reenable_force: assert property (
    s_reenable |-> ##2 ((s_q.cmp_of & $past(en_mask, 2)) ==
                        $past(en_mask, 2)))
    else $error("re-enable did not raise over faults");
  a_cnt_write_fill: assert property (
    wr_at(ftcm_pkg::OFF_TMO_CNT) |=>
      s_q.cnt == {$past(wdata_i[23:0]), ftcm_pkg::TMO_LOW_FILL})
    else $error("counter write wrong");
  a_cnt_hold: assert property (
    s_q.counter_reset_disable && frame_ok_i && !tick &&
    !wr_at(ftcm_pkg::OFF_TMO_CNT) |=> s_q.cnt == $past(s_q.cnt))
    else $error("frame reset counter while disabled");
  a_comm_masked: assert property (
    ((comm_err_i & s_q.comm_fault_mask & ~s_q.comm_f) != '0) |=>
      ((s_q.comm_f & $past(comm_err_i & s_q.comm_fault_mask
        & ~s_q.comm_f)) == '0))
    else $error("masked comm error set a flag");

endmodule

// ===== test/ftcm_host.sv
// Purpose: host model that drives the register port of the monitor
// Assumes: one master; strobes one cycle long, never both at once
// Notes:   read data is taken in the cycle after the read strobe
`timescale 1ns/1ps
module ftcm_host (
  // clock
  input  wire logic        mclk_i,
  // register port
  output logic      [11:0] addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [31:0] rdata_i
);
  initial begin
    addr_o  = 12'h000;
    wdata_o = 32'h0000_0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // user byte a sits in its own word; the index is the byte address
  function automatic logic [11:0] user_addr(input int a);
    return 12'h400 + 12'(a * 4);
  endfunction

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
  endtask

  // data is read before the edge's updates land, so it is the stood value
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    @(posedge mclk_i);
    d = rdata_i;
  endtask

  // quiet an unwanted channel with the widest window
  task automatic silence(input int ch);
    wr_reg(ftcm_pkg::OFF_AUX_LIM + 12'(ch * 4), 32'hFFFF_0000);
  endtask
endmodule

// ===== test/ftcm_top_tb.sv
// Purpose: self-checking bench for the monitor top
// Assumes: short tick period so counter wraps come quickly
// Notes:   expectations come from the register map, not the design
`timescale 1ns/1ps
module ftcm_top_tb;
  localparam int TICK = 8;
  logic        mclk_i;
  logic        rst_n_i;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        aux_valid;
  logic [2:0]  aux_chan;
  logic [15:0] aux_data;
  logic [15:0] cmp_under;
  logic [15:0] cmp_over;
  logic [6:0]  dac_over;
  logic [6:0]  dac_under;
  logic [15:0] chan_en;
  logic [7:0]  comm_err;
  logic        frame_ok;
  logic        fault_n;
  logic        tone;
  int          mismatches;
  int          check_count;
  logic [31:0] v;
  logic [31:0] cmp_exp [4] = '{32'h000A_0005, 32'h000A_0000, 32'h0, 32'h0};

  ftcm_top #(.TICK_CYCLES(TICK)) dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .aux_valid_i(aux_valid),
    .aux_chan_i(aux_chan), .aux_data_i(aux_data), .cmp_under_i(cmp_under),
    .cmp_over_i(cmp_over), .comparator_over_dac_o(dac_over),
    .comparator_under_dac_o(dac_under), .cmp_chan_en_o(chan_en),
    .comm_err_i(comm_err), .frame_ok_i(frame_ok), .fault_n_o(fault_n),
    .fault_tone_out_o(tone));

  ftcm_host host_u (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host_u.rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // one conversion result, valid for a single cycle
  task automatic aux_sample(input logic [2:0] ch, input logic [15:0] d);
    @(posedge mclk_i);
    aux_valid <= 1'b1;
    aux_chan  <= ch;
    aux_data  <= d;
    @(posedge mclk_i);
    aux_valid <= 1'b0;
  endtask

  task automatic comm_pulse(input logic [7:0] e);
    @(posedge mclk_i);
    comm_err <= e;
    @(posedge mclk_i);
    comm_err <= 8'h00;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    rst_n_i   = 1'b0;
    aux_valid = 1'b0;
    aux_chan  = 3'h0;
    aux_data  = 16'h0000;
    cmp_under = 16'h0000;
    cmp_over  = 16'h0000;
    comm_err  = 8'h00;
    frame_ok  = 1'b0;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    idle(2);
    rchk(ftcm_pkg::OFF_CTRL, 32'h0000_0100);
    chk(32'(chan_en), 32'h0000_FFFF);
    // no fault enabled yet, so the tone flips once per tick period
    v = 32'(tone);
    idle(TICK);
    chk(32'(v[0] ^ tone), 32'h0000_0001);
    rchk(12'h030, 32'h0000_0000);
    // byte 8 is not a term, and the two top bytes carry out of bit 31
    host_u.wr_reg(host_u.user_addr(3), 32'h0000_0011);
    host_u.wr_reg(host_u.user_addr(4), 32'h0000_00FF);
    host_u.wr_reg(host_u.user_addr(8), 32'h0000_0055);
    host_u.wr_reg(host_u.user_addr(224), 32'h0000_00FF);
    host_u.wr_reg(host_u.user_addr(227), 32'h0000_00FF);
    idle(3);
    rchk(ftcm_pkg::OFF_STORED_CHECKSUM_CMP, 32'hFE00_0110);
    rchk(ftcm_pkg::OFF_SYS_FLAGS, 32'h0000_0002);
    host_u.wr_reg(ftcm_pkg::OFF_STORED_CHECKSUM_STO, 32'hFE00_0110);
    idle(3);
    rchk(ftcm_pkg::OFF_SYS_FLAGS, 32'h0000_0000);
    host_u.wr_reg(ftcm_pkg::OFF_CTRL, 32'h0003_0101);
    host_u.wr_reg(ftcm_pkg::OFF_AUX_LIM + 12'h008, 32'h0200_0100);
    aux_sample(3'h2, 16'h0050);
    for (int i = 0; i < 20 && fault_n !== 1'b0; i++) @(posedge mclk_i);
    if (fault_n !== 1'b0) begin
      mismatches++;
      summarize();
    end
    chk(32'(tone), 32'h0000_0000);
    rchk(ftcm_pkg::OFF_AUX_FLAGS, 32'h0000_0004);
    rchk(ftcm_pkg::OFF_AUX_RES + 12'h008, 32'h0000_0050);
    host_u.wr_reg(ftcm_pkg::OFF_AUX_LIM + 12'h008, 32'h0200_0010);
    idle(3);
    rchk(ftcm_pkg::OFF_AUX_FLAGS, 32'h0000_0000);
    chk(32'(fault_n), 32'h0000_0001);
    host_u.wr_reg(ftcm_pkg::OFF_AUX_LIM + 12'h008, 32'h0040_0000);
    host_u.wr_reg(ftcm_pkg::OFF_AUX_FLAGS, 32'h0000_FFFF);
    idle(3);
    rchk(ftcm_pkg::OFF_AUX_FLAGS, 32'h0000_0400);
    host_u.silence(2);
    idle(3);
    rchk(ftcm_pkg::OFF_AUX_FLAGS, 32'h0000_0000);
    // a second channel must not disturb the first one's result
    aux_sample(3'h5, 16'h1234);
    idle(2);
    rchk(ftcm_pkg::OFF_AUX_RES + 12'h014, 32'h0000_1234);
    rchk(ftcm_pkg::OFF_AUX_RES + 12'h008, 32'h0000_0050);
    // upper bits fall on channels beyond the programmed count
    cmp_under <= 16'h0035;
    cmp_over  <= 16'h00CA;
    for (int c = 0; c < 4; c++) begin
      host_u.wr_reg(ftcm_pkg::OFF_CTRL, 32'h0000_0041 | 32'(c << 1));
      idle(3);
      rchk(ftcm_pkg::OFF_CMP_FLAGS, cmp_exp[c]);
    end
    host_u.wr_reg(ftcm_pkg::OFF_CTRL, 32'h0000_0041);
    idle(3);
    rchk(ftcm_pkg::OFF_CMP_FORCE, 32'h0000_000F);
    rchk(ftcm_pkg::OFF_CMP_FLAGS, 32'h000F_0005);
    chk(32'(chan_en), 32'h0000_000F);
    host_u.wr_reg(ftcm_pkg::OFF_CMP_DAC, 32'h0000_007F);
    host_u.wr_reg(ftcm_pkg::OFF_CMP_FORCE, 32'h0000_FFFF);
    idle(2);
    chk(32'({dac_under, dac_over}), 32'h0000_007F);
    rchk(ftcm_pkg::OFF_CMP_FORCE, 32'h0000_0000);
    cmp_under <= 16'h0000;
    cmp_over  <= 16'h0000;
    host_u.wr_reg(ftcm_pkg::OFF_CTRL, 32'h0000_0241);
    host_u.wr_reg(ftcm_pkg::OFF_TMO_CNT, 32'h0012_3456);
    host_u.rd_reg(ftcm_pkg::OFF_TMO_CNT, v);
    // a tick may land between write and read
    chk(32'(v inside {32'h0012_3456, 32'h0012_3457}), 32'h1);
    host_u.wr_reg(ftcm_pkg::OFF_SYS_FLAGS, 32'hFFFF_FFFF);
    host_u.wr_reg(ftcm_pkg::OFF_TMO_CNT, 32'h00FF_FFFF);
    @(posedge mclk_i);
    frame_ok <= 1'b1;
    @(posedge mclk_i);
    frame_ok <= 1'b0;
    idle(2 * TICK);
    rchk(ftcm_pkg::OFF_SYS_FLAGS, 32'h0000_0001);
    host_u.wr_reg(ftcm_pkg::OFF_SYS_FLAGS, 32'hFFFF_FFFF);
    host_u.wr_reg(ftcm_pkg::OFF_MASKS, 32'h0000_0101);
    comm_pulse(8'h03);
    idle(3);
    rchk(ftcm_pkg::OFF_SYS_FLAGS, 32'h0000_0200);
    host_u.wr_reg(ftcm_pkg::OFF_MASKS, 32'h0000_0002);
    idle(2);
    rchk(ftcm_pkg::OFF_SYS_FLAGS, 32'h0000_0200);
    // the new mask now blocks bit 1 but lets bit 2 through
    host_u.wr_reg(ftcm_pkg::OFF_SYS_FLAGS, 32'hFFFF_FFFF);
    comm_pulse(8'h06);
    idle(2);
    rchk(ftcm_pkg::OFF_SYS_FLAGS, 32'h0000_0400);
    summarize();
  end
endmodule
